// [dps_cfg.svh]
// Timing and field constants for the semaphore port controller
`ifndef DPS_CFG_SVH
`define DPS_CFG_SVH
`define DPS_CLK_NS 40
`define DPS_SEM_COUNT 8
`define DPS_IDX_W 3
`define DPS_ADDR_W 14
`define DPS_DATA_W 8
`define DPS_SEM_UPDATE_PULSE_NS 10
`define DPS_SEM_WRITE_TO_READ_NS 5
`define DPS_OE_ACCESS_NS 12
`define DPS_WRITE_PULSE_NS 15
`define DPS_FLAG_DELAY_SELECT_NS 20
`define DPS_FLAG_DELAY_MATCH_NS 20
`define DPS_CEIL_CYC(ns) (((ns) + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_PULSE_CYC `DPS_CEIL_CYC(`DPS_SEM_UPDATE_PULSE_NS)
`define DPS_READ_CYC `DPS_CEIL_CYC(`DPS_SEM_WRITE_TO_READ_NS + `DPS_OE_ACCESS_NS)
`define DPS_WRITE_CYC `DPS_CEIL_CYC(`DPS_WRITE_PULSE_NS)
`define DPS_SETTLE_CYC `DPS_CEIL_CYC(`DPS_FLAG_DELAY_SELECT_NS)
`define DPS_CNT_W 4
`endif

// [dps_pkg.sv]
// Types shared by the semaphore port controller
package dps_pkg;
  typedef enum logic [1:0] {
    DPS_OP_ACQUIRE = 2'b00,
    DPS_OP_RELEASE = 2'b01,
    DPS_OP_CHECK = 2'b10
  } dps_op_e;
  typedef struct packed {
    logic chip_enable_n;
    logic semaphore_select_n;
    logic read_write;
    logic output_enable_n;
    logic [13:0] address;
  } dps_pins_s;
  typedef struct packed {
    dps_op_e op;
    logic [2:0] semaphore_index;
  } dps_req_s;
endpackage : dps_pkg

// [dps_sync.sv]
// Two-flop synchroniser for device pins
`timescale 1ns/1ps
module dps_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : dps_sync

// [dps_sem_host.sv]
// Port controller that acquires, releases and checks hardware semaphores
// Summary of operation
// - Request by writing zero to latch
// - Read back: zero owns, one keeps polling (the code stops after POLL_LIMIT retries and raises done_timeout)
// - Deassert select for update pulse before reading
// - Release or cancel by writing one
// - Select low, chip enable high selects latches
// - OE and read/write act as memory
// - Master flag feeds each slave input
// - Delay slave writes until flag settles
`timescale 1ns/1ps
`include "dps_cfg.svh"
module dps_sem_host #(
  parameter int POLL_LIMIT = 255
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire dps_pkg::dps_req_s req,
  output logic req_ready,
  output logic done_valid,
  output logic done_owned,
  output logic done_timeout,
  output dps_pkg::dps_pins_s pins,
  output logic [7:0] data_out,
  output logic [7:0] data_oe_n,
  input wire logic [7:0] data_in,
  input wire logic busy_in_n
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETTLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_GAP = 3'b011,
    ST_READ = 3'b100,
    ST_DONE = 3'b101
  } dps_state_e;
  ////////////////////////////////////////////////////////////////////////////
  dps_state_e state_reg, state_next;
  logic [`DPS_CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] poll_reg, poll_next;
  dps_pkg::dps_req_s cur_reg;
  logic owned_reg, timeout_reg;
  logic [7:0] data_sync;
  logic busy_sync_n;
  // Pins from the device are asynchronous to clk
  // Busy flag joins the data pins so one synchroniser serves both
  dps_sync #(.WIDTH(9)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({busy_in_n, data_in}),
    .sync_out({busy_sync_n, data_sync})
  );
  // Each phase lasts count plus one cycles, so a zero count still gives one
  function automatic logic [`DPS_CNT_W-1:0] to_cnt(input int cycles);
    to_cnt = cycles[`DPS_CNT_W-1:0];
  endfunction : to_cnt
  ////////////////////////////////////////////////////////////////////////////
  wire cnt_zero = (cnt_reg == '0);
  wire is_check = (cur_reg.op == dps_pkg::DPS_OP_CHECK);
  wire is_release = (cur_reg.op == dps_pkg::DPS_OP_RELEASE);
  wire write_bit = is_release;
  wire sem_read_zero = ~data_sync[0];
  wire in_write = (state_reg == ST_WRITE) || (state_reg == ST_SETTLE);
  wire in_read = (state_reg == ST_READ);
  wire poll_out = (poll_reg == POLL_LIMIT[7:0]);
  assign req_ready = (state_reg == ST_IDLE);
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    poll_next = poll_reg;
    case (state_reg)
      ST_IDLE:
      begin
        poll_next = '0;
        if (req_valid)
        begin
          // Settle wait covers the slave-flag case before any write
          state_next = (req.op == dps_pkg::DPS_OP_CHECK) ? ST_READ : ST_SETTLE;
          cnt_next = (req.op == dps_pkg::DPS_OP_CHECK) ? to_cnt(`DPS_READ_CYC) : to_cnt(`DPS_SETTLE_CYC);
        end
      end
      ST_SETTLE:
      begin
        if (cnt_zero)
        begin
          state_next = ST_WRITE;
          cnt_next = to_cnt(`DPS_WRITE_CYC);
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      ST_WRITE:
      begin
        if (cnt_zero)
        begin
          state_next = is_release ? ST_DONE : ST_GAP;
          cnt_next = to_cnt(`DPS_PULSE_CYC);
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      ST_GAP:
      begin
        if (cnt_zero)
        begin
          state_next = ST_READ;
          cnt_next = to_cnt(`DPS_READ_CYC);
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      ST_READ:
      begin
        // Extra two cycles cover the input synchroniser
        if (cnt_zero)
        begin
          if (sem_read_zero || is_check || poll_out)
            state_next = ST_DONE;
          else
          begin
            state_next = ST_GAP;
            poll_next = poll_reg + 8'h01;
            cnt_next = to_cnt(`DPS_PULSE_CYC);
          end
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      ST_DONE:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      poll_reg <= 8'h00;
      cur_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= (state_reg == ST_READ && cnt_zero) ? cnt_next : ((state_next == ST_READ && state_reg != ST_READ)
        ? cnt_next + to_cnt(2) : cnt_next);
      poll_reg <= poll_next;
      // Request is copied so the requester may drop it after the take
      if (req_ready && req_valid)
        cur_reg <= req;
    end
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      owned_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end
    else if (state_reg == ST_READ && cnt_zero)
    begin
      owned_reg <= sem_read_zero;
      timeout_reg <= ~sem_read_zero && ~is_check && poll_out;
    end
    else if (state_reg == ST_IDLE)
    begin
      owned_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pins <= {1'b1, 1'b1, 1'b1, 1'b1, 14'h0000};
      data_out <= 8'h00;
      data_oe_n <= 8'hff;
      done_valid <= 1'b0;
      done_owned <= 1'b0;
      done_timeout <= 1'b0;
    end
    else
    begin
      // Chip enable stays high so only the latches are ever reached
      pins.chip_enable_n <= 1'b1;
      pins.semaphore_select_n <= ~((state_next == ST_WRITE) || (state_next == ST_READ));
      pins.read_write <= ~(state_next == ST_WRITE);
      pins.output_enable_n <= ~(state_next == ST_READ);
      pins.address <= {11'h000, (state_next == ST_IDLE) ? cur_reg.semaphore_index
        : (req_ready && req_valid ? req.semaphore_index : cur_reg.semaphore_index)};
      data_out <= {7'h00, (req_ready && req_valid) ? (req.op == dps_pkg::DPS_OP_RELEASE) : write_bit};
      data_oe_n <= (state_next == ST_WRITE || state_next == ST_SETTLE) ? 8'h00 : 8'hff;
      // Results are registered and shown for one cycle only
      done_valid <= (state_reg == ST_DONE);
      done_owned <= (state_reg == ST_DONE) && owned_reg;
      done_timeout <= (state_reg == ST_DONE) && timeout_reg;
    end
  end
  // Flag is only sampled; write timing relies on the fixed settle wait
  // Trade-off: simpler than tracking the flag edge, but every write
  // pays a settle phase even when no contention is present
  wire unused_flag = busy_sync_n & in_write & in_read;
endmodule : dps_sem_host

// [dps_sem_host_chk.sv]
// Pin checker for the semaphore port controller
`timescale 1ns/1ps
module dps_sem_host_chk #(
  parameter int POLL_LIMIT = 255
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire dps_pkg::dps_req_s req,
  input wire logic req_ready,
  input wire logic done_valid,
  input wire dps_pkg::dps_pins_s pins,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic sel = !pins.semaphore_select_n;
  wire logic wr = sel && !pins.read_write;
  sequence s_take(dps_pkg::dps_op_e op);
    req_valid && req_ready && req.op == op;
  endsequence
  sequence s_write(logic [7:0] d);
    ##3 wr && data_out == d;
  endsequence
  sequence s_wr_end;
    wr ##1 !wr;
  endsequence
  a_sel_ce_high: assert property (sel |-> pins.chip_enable_n) else $error("select with chip enable low");
  a_acq_zero: assert property (s_take(dps_pkg::DPS_OP_ACQUIRE) |-> s_write(8'h00)) else $error("bad acquire");
  a_rel_one: assert property (s_take(dps_pkg::DPS_OP_RELEASE) |-> s_write(8'h01)) else $error("bad release");
  a_rel_done: assert property (s_take(dps_pkg::DPS_OP_RELEASE) |-> ##6 done_valid) else $error("late");
  a_index_bits: assert property (req_valid && req_ready |=> pins.address[2:0] == $past(req.semaphore_index))
    else $error("wrong index");
  a_update_gap: assert property (s_wr_end |-> !sel ##1 !sel) else $error("no gap after write");
  a_write_drive: assert property (wr |-> data_oe_n == 8'h00) else $error("write not driven");
  a_read_float: assert property (sel && pins.read_write |-> !pins.output_enable_n && data_oe_n == 8'hff)
    else $error("bad read");
endmodule : dps_sem_host_chk
bind dps_sem_host dps_sem_host_chk #(.POLL_LIMIT(POLL_LIMIT)) u_chk (.clk(clk), .reset_n(reset_n),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .done_valid(done_valid), .pins(pins),
  .data_out(data_out), .data_oe_n(data_oe_n));

// [dps_dev_model.sv]
// Behavioural semaphore device with a second port
`timescale 1ns/1ps
module dps_dev_model (
  input wire logic clk,
  input wire dps_pkg::dps_pins_s pins,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe_n,
  output logic [7:0] data_in,
  output logic busy_in_n,
  input wire logic r_wr,
  input wire logic r_d0,
  input wire logic [2:0] r_idx,
  output logic [7:0] far_bits
);
  logic [7:0] own [2] = '{8'h00, 8'h00};
  logic [7:0] pend [2] = '{8'h00, 8'h00};
  logic [7:0] q = 8'hff;
  logic [7:0] last = 8'h00;
  wire logic wr = !pins.semaphore_select_n && pins.chip_enable_n && !pins.read_write;
  wire logic rd = !pins.semaphore_select_n && pins.chip_enable_n && pins.read_write && !pins.output_enable_n;
  task automatic put(input int s, input logic [2:0] i, input logic d);
    logic o;
    logic po;
    o = own[1-s][i];
    po = pend[1-s][i] && own[s][i] && d;
    own[s][i] = d ? 1'b0 : (own[s][i] || !o);
    pend[s][i] = !d && o;
    own[1-s][i] = o || po;
    pend[1-s][i] = pend[1-s][i] && !po;
  endtask : put
  // Host side handled first: a tie goes to it
  always @(posedge clk)
  begin
    if (wr)
      put(0, pins.address[2:0], data_out[0]);
    if (r_wr)
      put(1, r_idx, r_d0);
  end
  always @(posedge rd) q = {8{!own[0][pins.address[2:0]]}};
  // No pull-up: a released bus shows the inverse, never a stale match
  always @(posedge clk) last <= data_in;
  assign data_in = rd ? q : (!data_oe_n[0] ? data_out : ~last);
  assign busy_in_n = 1'b1;
  assign far_bits = ~own[1];
endmodule : dps_dev_model

// [dps_sem_host_tb.sv]
// Self-checking bench for the semaphore port controller
`timescale 1ns/1ps
module dps_sem_host_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  dps_pkg::dps_req_s req = '0;
  logic req_ready, done_valid, done_owned, done_timeout, busy_in_n;
  dps_pkg::dps_pins_s pins;
  logic [7:0] data_out, data_oe_n, data_in, far_bits;
  logic r_wr = 1'b0;
  logic r_d0 = 1'b1;
  logic [2:0] r_idx = 3'h0;
  int bad_count = 0;
  int checked = 0;
  initial forever #20 clk = ~clk;
  // Short poll limit keeps the refused-acquire case brief
  dps_sem_host #(.POLL_LIMIT(3)) u_dps_sem_host (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .done_valid(done_valid), .done_owned(done_owned),
    .done_timeout(done_timeout), .pins(pins), .data_out(data_out), .data_oe_n(data_oe_n),
    .data_in(data_in), .busy_in_n(busy_in_n));
  dps_dev_model u_dps_dev_model (.clk(clk), .pins(pins), .data_out(data_out), .data_oe_n(data_oe_n),
    .data_in(data_in), .busy_in_n(busy_in_n), .r_wr(r_wr), .r_d0(r_d0), .r_idx(r_idx), .far_bits(far_bits));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input dps_pkg::dps_op_e op, input logic [2:0] i, input logic ow, input logic to);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= {op, i};
    @(posedge clk);
    req_valid <= 1'b0;
    for (int n = 0; n < 100 && done_valid !== 1'b1; n++)
      @(posedge clk) #1;
    chk(done_valid, 1'b1);
    chk(done_owned, ow);
    chk(done_timeout, to);
  endtask : go
  task automatic far(input logic [2:0] i, input logic d);
    @(posedge clk);
    r_wr <= 1'b1;
    r_idx <= i;
    r_d0 <= d;
    @(posedge clk);
    r_wr <= 1'b0;
  endtask : far
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_each();
    for (logic [3:0] i = 4'h0; i < 4'h8; i++)
    begin
      go(dps_pkg::DPS_OP_ACQUIRE, i[2:0], 1'b1, 1'b0);
      chk(far_bits, 8'hff);
      go(dps_pkg::DPS_OP_CHECK, i[2:0], 1'b1, 1'b0);
      go(dps_pkg::DPS_OP_RELEASE, i[2:0], 1'b0, 1'b0);
      go(dps_pkg::DPS_OP_CHECK, i[2:0], 1'b0, 1'b0);
    end
  endtask : t_each
  task automatic t_pass();
    far(3'h2, 1'b0);
    fork
      go(dps_pkg::DPS_OP_ACQUIRE, 3'h2, 1'b1, 1'b0);
      begin
        repeat (5) @(posedge clk);
        far(3'h2, 1'b1);
      end
    join
    chk(far_bits, 8'hff);
    go(dps_pkg::DPS_OP_RELEASE, 3'h2, 1'b0, 1'b0);
  endtask : t_pass
  task automatic t_hold();
    far(3'h6, 1'b0);
    go(dps_pkg::DPS_OP_ACQUIRE, 3'h6, 1'b0, 1'b1);
    chk(far_bits, 8'hbf);
  endtask : t_hold
  initial
  begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_each();
    t_pass();
    t_hold();
    summarize();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule : dps_sem_host_tb
